//--- verilog/iar_pkg.sv
// shared constants and types for the identification reader
package iar_pkg;
  localparam int          PTR_W         = 5;
  localparam int          FIFO_DEPTH    = 4;
  localparam int          BYTE_W        = 8;
  localparam logic [6:0]  SLAVE_ADDR    = 7'h40;
  localparam logic [4:0]  FILL_ADDR     = 5'h10;
  localparam logic [7:0]  FILL_BYTE     = 8'hff;
  localparam logic [4:0]  PTR_RESET     = 5'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
  localparam int          STD_RATE_KBPS = 100;
  // identifier text is arbitrary; last byte is the end-of-transmission code
  localparam logic [127:0] ID_TEXT      = {"ID-READER BLOCK", 8'h04};

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WADDR    = 7'h08,
    ST_WACK     = 7'h10,
    ST_RDATA    = 7'h20,
    ST_RACK     = 7'h40
  } iar_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } iar_bus_t;
endpackage

//--- verilog/iar_reader.sv
// identification memory reader: i2c read-only slave with prefetch fifo
// What this block does
// - the block acknowledges its address and the logic address byte and loads the pointer.
// - after acknowledging a read address the block shifts out bytes from the pointer on.
// - each master acknowledge advances the pointer below 0x10 (from 0x10 up it becomes 0x10) and the next byte is sent.
// - a master not-acknowledge makes the block release the data line.
// - past the last identifier byte the filler byte is resent for every acknowledge.
// - a read may start directly with the read address, skipping the pointer write.
// - only the seven-bit address 1000000 is answered, in both directions.
// - the memory holds the identifier ending in end-of-transmission, then filler ff.
// - transfers follow the master's scl; the bench runs them at 125 ns per bit, not the standard-mode rate.
`timescale 1ns/10ps

module iar_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // fill side
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  // drain side
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  assign wr_ready = (cnt_reg != (AW+1)'(D)) && !flush;
  assign rd_valid = (cnt_reg != '0) && !flush;
  assign rd_data  = mem_reg[rp_reg];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  always_comb begin
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wp_next  = '0;
      rp_next  = '0;
      cnt_next = '0;
    end else begin
      if (push) wp_next = (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_next = (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
      if (push && !pop) cnt_next = cnt_reg + 1'b1;
      else if (pop && !push) cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
    if (push) mem_reg[wp_reg] <= wr_data;
  end
endmodule

module iar_reader (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // i2c pins, open drain data
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe
);
  iar_pkg::iar_bus_t   s1_reg, s2_reg, s3_reg;
  iar_pkg::iar_state_t st_reg, st_next;
  logic [7:0]  shift_reg, shift_next;
  logic [3:0]  bit_reg, bit_next;
  logic [4:0]  ptr_reg, ptr_next, fetch_reg, fetch_next;
  logic        oe_reg, oe_next, flush, pop;
  logic        scl_rise, scl_fall, start_evt, stop_evt;
  logic        f_wready, f_rvalid;
  logic [7:0]  f_rdata, tx_byte;

  // bytes 0x00..0x0f are identifier, anything above reads as filler
  function automatic logic [7:0] rom_byte(input logic [4:0] a);
    if (a >= iar_pkg::FILL_ADDR) return iar_pkg::FILL_BYTE;
    return iar_pkg::ID_TEXT[8*(15 - int'(a)) +: 8];
  endfunction
  function automatic logic [4:0] ptr_step(input logic [4:0] p);
    return (p >= iar_pkg::FILL_ADDR) ? iar_pkg::FILL_ADDR : p + 5'h01;
  endfunction
  // only s2/s3 are looked at; s1 is the metastability stage
  // oversampling at 100 MHz is ample for the standard-mode rate
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_reg <= '{scl: 1'b1, sda: 1'b1};
      s2_reg <= '{scl: 1'b1, sda: 1'b1};
      s3_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      s1_reg <= '{scl: scl_i, sda: sda_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign scl_rise  = s2_reg.scl && !s3_reg.scl;
  assign scl_fall  = !s2_reg.scl && s3_reg.scl;
  assign start_evt = s2_reg.scl && s3_reg.scl && !s2_reg.sda && s3_reg.sda;
  assign stop_evt  = s2_reg.scl && s3_reg.scl && s2_reg.sda && !s3_reg.sda;
  // empty fifo should not happen at slow scl; filler keeps the line sane
  assign tx_byte   = f_rvalid ? f_rdata : iar_pkg::FILL_BYTE;
  assign sda_o     = 1'b0;
  assign sda_oe    = oe_reg;

  always_comb begin
    st_next    = st_reg;
    shift_next = shift_reg;
    bit_next   = bit_reg;
    ptr_next   = ptr_reg;
    oe_next    = oe_reg;
    flush      = 1'b0;
    pop        = 1'b0;
    if (stop_evt) begin
      st_next = iar_pkg::ST_IDLE;
      oe_next = 1'b0;
      flush   = 1'b1;
    end else if (start_evt) begin
      st_next  = iar_pkg::ST_ADDR;
      bit_next = '0;
      oe_next  = 1'b0;
      flush    = 1'b1;
    end else begin
      case (st_reg)
        iar_pkg::ST_IDLE: oe_next = 1'b0;
        iar_pkg::ST_ADDR, iar_pkg::ST_WADDR: begin
          if (scl_rise && bit_reg != iar_pkg::BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], s2_reg.sda};
            bit_next   = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == iar_pkg::BITS_PER_BYTE) begin
            if (st_reg == iar_pkg::ST_WADDR) begin
              st_next  = iar_pkg::ST_WACK;
              oe_next  = 1'b1;
              ptr_next = (shift_reg[7:5] != 3'h0) ? iar_pkg::FILL_ADDR
                         : shift_reg[4:0];
              flush    = 1'b1;
            end else if (shift_reg[7:1] == iar_pkg::SLAVE_ADDR) begin
              st_next = iar_pkg::ST_ADDR_ACK;
              oe_next = 1'b1;
            end else begin
              st_next = iar_pkg::ST_IDLE;
            end
          end
        end
        iar_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_next = '0;
            if (shift_reg[0]) begin
              // read direction, with or without a prior pointer write
              st_next    = iar_pkg::ST_RDATA;
              shift_next = tx_byte;
              pop        = 1'b1;
              oe_next    = !tx_byte[7];
            end else begin
              st_next = iar_pkg::ST_WADDR;
              oe_next = 1'b0;
            end
          end
        end
        // further written bytes are not acknowledged
        iar_pkg::ST_WACK: begin
          if (scl_fall) begin
            st_next = iar_pkg::ST_IDLE;
            oe_next = 1'b0;
          end
        end
        iar_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_reg == iar_pkg::LAST_TX_BIT) begin
              st_next = iar_pkg::ST_RACK;
              oe_next = 1'b0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              bit_next   = bit_reg + 4'h1;
              oe_next    = !shift_reg[6];
            end
          end
        end
        iar_pkg::ST_RACK: begin
          if (scl_rise) begin
            shift_next[0] = !s2_reg.sda;
          end else if (scl_fall) begin
            bit_next = '0;
            if (shift_reg[0]) begin
              st_next    = iar_pkg::ST_RDATA;
              ptr_next   = ptr_step(ptr_reg);
              shift_next = tx_byte;
              pop        = 1'b1;
              oe_next    = !tx_byte[7];
            end else begin
              st_next = iar_pkg::ST_IDLE;
              oe_next = 1'b0;
              flush   = 1'b1;
            end
          end
        end
        default: begin
          st_next = iar_pkg::ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // prefetch runs ahead of the pointer, restarted from it on every flush
  always_comb begin
    fetch_next = fetch_reg;
    if (flush) fetch_next = ptr_next;
    else if (f_wready) fetch_next = ptr_step(fetch_reg);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg    <= iar_pkg::ST_IDLE;
      shift_reg <= '0;
      bit_reg   <= '0;
      ptr_reg   <= iar_pkg::PTR_RESET;
      fetch_reg <= iar_pkg::PTR_RESET;
      oe_reg    <= 1'b0;
    end else begin
      st_reg    <= st_next;
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      ptr_reg   <= ptr_next;
      fetch_reg <= fetch_next;
      oe_reg    <= oe_next;
    end
  end

  iar_fifo #(.W(iar_pkg::BYTE_W), .D(iar_pkg::FIFO_DEPTH)) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .flush    (flush),
    .wr_valid (!flush),
    .wr_ready (f_wready),
    .wr_data  (rom_byte(fetch_reg)),
    .rd_valid (f_rvalid),
    .rd_ready (pop),
    .rd_data  (f_rdata)
  );
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_addr_match: assert property ((st_reg == iar_pkg::ST_ADDR) && scl_fall && !start_evt && !stop_evt
    && bit_reg == 4'h8 && shift_reg[7:1] == 7'h40 |=> oe_reg && st_reg == iar_pkg::ST_ADDR_ACK)
    else $error("own address not acknowledged");
  a_addr_other: assert property ((st_reg == iar_pkg::ST_ADDR) && scl_fall && !start_evt && !stop_evt
    && bit_reg == 4'h8 && shift_reg[7:1] != 7'h40 |=> !oe_reg && st_reg == iar_pkg::ST_IDLE)
    else $error("foreign address answered");
  a_ptr_load: assert property ((st_reg == iar_pkg::ST_WADDR) && scl_fall && !start_evt
    && !stop_evt && bit_reg == 4'h8 && shift_reg < 8'h10 |=> ptr_reg == $past(shift_reg[4:0])
    && oe_reg)
    else $error("logic address not loaded");
  a_fast_read: assert property ((st_reg == iar_pkg::ST_ADDR_ACK) && scl_fall && shift_reg[0]
    && !start_evt && !stop_evt |=> st_reg == iar_pkg::ST_RDATA && bit_reg == 4'h0)
    else $error("read did not begin after address");
  a_ack_step: assert property ((st_reg == iar_pkg::ST_RACK) && scl_fall && shift_reg[0]
    && ptr_reg < 5'h10 && !start_evt && !stop_evt |=> ptr_reg == $past(ptr_reg) + 5'h01)
    else $error("pointer did not advance on acknowledge");
  a_fill_hold: assert property ((st_reg == iar_pkg::ST_RACK) && scl_fall && shift_reg[0]
    && ptr_reg == 5'h10 && !start_evt && !stop_evt |=> ptr_reg == 5'h10 && shift_reg == 8'hff)
    else $error("filler byte not repeated");
  a_nack_free: assert property ((st_reg == iar_pkg::ST_RACK) && scl_fall && !shift_reg[0]
    && !start_evt && !stop_evt |=> !sda_oe [*3])
    else $error("data line held after not-acknowledge");
  a_bit_drive: assert property ((st_reg == iar_pkg::ST_RDATA) && s2_reg.scl && s3_reg.scl
    |-> sda_oe == !shift_reg[7])
    else $error("wrong data bit on the line");
  a_stop_idle: assert property (stop_evt |=> st_reg == iar_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not end the transfer");
  a_reset_ptr: assert property (disable iff (1'b0) !rst_n |=> ptr_reg == 5'h00
    && st_reg == iar_pkg::ST_IDLE)
    else $error("pointer not zero after reset");
  c_ptr_write: cover property (st_reg == iar_pkg::ST_WACK && scl_fall);
  c_read_ack:  cover property (st_reg == iar_pkg::ST_RACK && scl_fall && shift_reg[0]);
  c_fill_rep:  cover property (ptr_reg == 5'h10 && st_reg == iar_pkg::ST_RDATA);
  c_nack_end:  cover property (st_reg == iar_pkg::ST_RACK && scl_fall && !shift_reg[0]);
endmodule

//--- verif/iar_master.sv
// i2c master model that reads the identification memory
`timescale 1ns/10ps

module iar_master (
  // system clock, only to align frame starts
  input  wire logic clock,
  // link pins, data is open drain
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // quarter of the 125 ns link period
  localparam realtime QTR = 31.25;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // data changes only while scl is low, sampled mid high
  task automatic bit_cyc(input logic drv_low, output logic smp);
    #(QTR) sda_low = drv_low;
    #(QTR) scl = 1'b1;
    #(QTR) smp = sda;
    #(QTR) scl = 1'b0;
  endtask

  // start or repeated start, leaves scl low
  task automatic start();
    @(posedge clock);
    #1 sda_low = 1'b0;
    #(QTR) scl = 1'b1;
    #(QTR) sda_low = 1'b1;
    #(QTR) scl = 1'b0;
  endtask

  // stop: data rises while scl is high, leaves the bus idle
  task automatic stop();
    #(QTR) sda_low = 1'b1;
    #(QTR) scl = 1'b1;
    #(QTR) sda_low = 1'b0;
    #(QTR);
  endtask

  // one byte out msb first; ack is the slave pulling the ninth bit low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(!b[i], smp);
    end
    bit_cyc(1'b0, smp);
    ack = !smp;
  endtask

  // one byte in; ninth bit pulled low to ack, left high to end the read
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b0, smp);
      b[i] = smp;
    end
    bit_cyc(ack_it, smp);
  endtask
endmodule

//--- verif/iar_reader_test.sv
// self-checking bench for the identification reader
`timescale 1ns/10ps

module iar_reader_test;
  logic clock;
  logic rst_n;
  logic scl;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic m_low;
  int   err_total;
  int   tests_run;

  // released wire floats high through the pull-up
  assign sda = sda_oe ? sda_o : !m_low;

  iar_reader iar_reader_inst (
    .clock  (clock),
    .rst_n  (rst_n),
    .scl_i  (scl),
    .sda_i  (sda),
    .sda_o  (sda_o),
    .sda_oe (sda_oe)
  );

  iar_master iar_master_inst (
    .clock   (clock),
    .scl     (scl),
    .sda_low (m_low),
    .sda     (sda)
  );

  initial begin
    clock = 1'b0;
  end
  always #5 clock = ~clock;

  // past the identifier every location reads as filler
  function automatic logic [7:0] mem_at(input int a);
    if (a >= 16) begin
      return iar_pkg::FILL_BYTE;
    end
    return iar_pkg::ID_TEXT[127 - 8 * a -: 8];
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic set_ptr(input logic [7:0] ptr, input logic rep_start);
    logic ack;
    iar_master_inst.start();
    iar_master_inst.send_byte({iar_pkg::SLAVE_ADDR, 1'b0}, ack);
    cmp1(ack, 1'b1, "write address ack");
    iar_master_inst.send_byte(ptr, ack);
    cmp1(ack, 1'b1, "logic address ack");
    if (!rep_start) begin
      iar_master_inst.stop();
    end
  endtask

  // reads n bytes, acking all but the last one
  task automatic read_run(input int first, input int n);
    logic       ack;
    logic [7:0] b;
    iar_master_inst.start();
    iar_master_inst.send_byte({iar_pkg::SLAVE_ADDR, 1'b1}, ack);
    cmp1(ack, 1'b1, "read address ack");
    for (int i = 0; i < n; i++) begin
      iar_master_inst.recv_byte(i < n - 1, b);
      cmp8(b, mem_at(first + i), "read data");
    end
    repeat (6) @(posedge clock);
    #1;
    cmp1(sda_oe, 1'b0, "line released after nack");
    iar_master_inst.stop();
  endtask

  task automatic t_accel();
    read_run(0, 2);
    // the nacked byte is sent again by the next read
    read_run(1, 1);
    $display("test accelerated read done");
  endtask

  task automatic t_every_ptr();
    for (int a = 0; a <= 16; a++) begin
      // odd pointers go on with a repeated start instead of stop
      set_ptr(8'(a), a[0]);
      read_run(a, 1);
    end
    $display("test every pointer done");
  endtask

  task automatic t_filler();
    set_ptr(8'h0e, 1'b0);
    read_run(14, 6);
    set_ptr(8'h1f, 1'b0);
    read_run(16, 2);
    $display("test filler done");
  endtask

  task automatic t_wrong_addr();
    logic       ack;
    logic [6:0] bad [3];
    bad = '{7'h41, 7'h00, 7'h20};
    for (int i = 0; i < 3; i++) begin
      iar_master_inst.start();
      iar_master_inst.send_byte({bad[i], i[0]}, ack);
      cmp1(ack, 1'b0, "foreign address ack");
      iar_master_inst.stop();
    end
    read_run(16, 1);
    $display("test foreign address done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // whole run takes about 115 us of link traffic
  initial begin
    #400000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst_n     = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    cmp1(sda_oe, 1'b0, "idle after reset");
    t_accel();
    t_every_ptr();
    t_filler();
    t_wrong_addr();
    end_of_test();
  end
endmodule
